// ==== jmv_pkg.sv ====
// Package for the joystick message validator: register map, field layout, reset values, timing.
// Assumes a 20 MHz system clock; every user writes jmv_pkg::name.
package jmv_pkg;
  localparam int unsigned CLK_HZ          = 20_000_000;
  // Register offsets (byte addresses, one word each).
  localparam logic [7:0] OFF_PRESENT      = 8'h00;
  localparam logic [7:0] OFF_TYPE         = 8'h04;
  localparam logic [7:0] OFF_GROUP        = 8'h08;
  localparam logic [7:0] OFF_SRC_ADDR     = 8'h0C;
  localparam logic [7:0] OFF_FLOW_THR     = 8'h10;
  localparam logic [7:0] OFF_TOLERANCE    = 8'h14;
  localparam logic [7:0] OFF_XCHK_TIME    = 8'h18;
  localparam logic [7:0] OFF_TIMEOUT      = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLEAR    = 8'h24;
  localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h28;
  localparam logic [7:0] OFF_POSITION     = 8'h2C;
  localparam logic [7:0] OFF_STATE        = 8'h30;
  // Reset values.
  localparam logic [7:0]  RST_PRESENT     = 8'h00;
  localparam logic [7:0]  RST_TYPE        = 8'h02;
  localparam logic [15:0] RST_GROUP       = 16'hFDD6;
  localparam logic [7:0]  RST_SRC_ADDR    = 8'h4E;
  localparam logic [7:0]  RST_FLOW_THR    = 8'h0A;
  localparam logic [10:0] RST_TOLERANCE   = 11'h00A;
  localparam logic [15:0] RST_XCHK_MS     = 16'h0064;
  localparam logic [15:0] RST_TIMEOUT_MS  = 16'h0064;
  // Setting codes.
  localparam logic [7:0]  PRESENT_NO      = 8'h00;
  localparam logic [7:0]  PRESENT_YES     = 8'hFF;
  localparam logic [7:0]  TYPE_OPEN_LOOP  = 8'h00;
  localparam logic [7:0]  TYPE_CLOSED     = 8'h01;
  localparam logic [7:0]  TYPE_MINI_WHEEL = 8'h02;
  localparam logic [7:0]  TYPE_ANALOGUE   = 8'h03;
  localparam logic [7:0]  TYPE_CAN_STICK  = 8'h14;
  localparam logic [7:0]  SRC_ADDR_MAX    = 8'hFD;
  localparam logic [15:0] GRP_BASIC_1     = 16'hFDD6;
  localparam logic [15:0] GRP_EXT_1       = 16'hFDD7;
  localparam logic [15:0] GRP_BASIC_2     = 16'hFDD8;
  localparam logic [15:0] GRP_EXT_2       = 16'hFDD9;
  // Status byte patterns over bits 6..1 of byte 1.
  localparam logic [5:0]  STAT_RIGHT      = 6'h10;
  localparam logic [5:0]  STAT_LEFT       = 6'h04;
  localparam logic [5:0]  STAT_NEUTRAL    = 6'h01;
  localparam logic [9:0]  POS_MAX         = 10'h3E8;
  // Millisecond tick.
  localparam int unsigned MS_NS           = 1_000_000;
  localparam int unsigned CLK_NS          = 50;
  localparam int unsigned MS_CYCLES       = MS_NS / CLK_NS;
  // Interrupt bits.
  localparam int unsigned IRQ_STATUS_BAD  = 0;
  localparam int unsigned IRQ_RANGE       = 1;
  localparam int unsigned IRQ_MISMATCH    = 2;
  localparam int unsigned IRQ_XCHK        = 3;
  localparam int unsigned IRQ_TIMEOUT     = 4;
  localparam int unsigned IRQ_MSG         = 5;
  localparam int unsigned IRQ_W           = 6;
endpackage

// ==== jmv_decode.sv ====
// Decoder for one channel: status bits and 10-bit magnitude into a signed scaled position.
// Purely combinational; both channels instantiate it so each computes its own result.
`timescale 1ns/1ps
module jmv_decode (
  // Message bytes 1 and 2, already in true polarity.
  input  wire logic [7:0]         byte1,
  input  wire logic [7:0]         byte2,
  // Results.
  output logic signed [11:0]      scaled,
  output logic                    status_bad,
  output logic                    range_bad,
  output logic                    mismatch
);
  logic [5:0]  stat;
  logic [10:0] mag;

  // Byte 1 bits 6..1 carry the status; magnitude is byte 2 and byte 1 bits 7 and 0 above it.
  always_comb begin
    stat       = byte1[6:1];
    mag        = {1'b0, byte1[7], byte1[0], byte2[7:0]};
    status_bad = 1'b1;
    mismatch   = 1'b0;
    scaled     = 12'sh000;
    if (stat == jmv_pkg::STAT_RIGHT) begin
      status_bad = 1'b0;
      scaled     = $signed({1'b0, mag});
      mismatch   = (mag == 11'h000);
    end else if (stat == jmv_pkg::STAT_LEFT) begin
      status_bad = 1'b0;
      scaled     = -$signed({1'b0, mag});
      mismatch   = (mag == 11'h000);
    end else if (stat == jmv_pkg::STAT_NEUTRAL) begin
      status_bad = 1'b0;
      scaled     = 12'sh000;
      mismatch   = (mag != 11'h000);
    end
    range_bad = (mag > {1'b0, jmv_pkg::POS_MAX});
  end
endmodule // jmv_decode

// ==== jmv_validator.sv ====
// Joystick message validator: filters received frames, validates both channels, raises safe state.
// Assumes a CAN receiver on the same clock presenting one frame per one-cycle valid pulse.
`timescale 1ns/1ps
module jmv_validator #(
  // Clock cycles per millisecond tick; the tick counter holds 15 bits.
  parameter int unsigned MS_CYCLES = jmv_pkg::MS_CYCLES
) (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Received frame from the CAN receiver.
  input  wire logic               rx_valid,
  input  wire logic               rx_inverted,
  input  wire logic [15:0]        rx_group,
  input  wire logic [7:0]         rx_src_addr,
  input  wire logic [63:0]        rx_data,
  // Register port.
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  // Results.
  output logic signed [11:0]      position,
  output logic                    safe_state,
  output logic                    aux_present,
  output logic                    type_can_stick,
  output logic                    type_open_loop,
  output logic                    irq
);
  typedef struct packed {
    logic [7:0]         present;
    logic [7:0]         dev_type;
    logic [15:0]        group;
    logic [7:0]         src_addr;
    logic [7:0]         flow_thr;
    logic [10:0]        tolerance;
    logic [15:0]        xchk_ms;
    logic [15:0]        timeout_ms;
    logic [5:0]         irq_status;
    logic [5:0]         irq_enable;
    logic [15:0]        main_bytes;
    logic [15:0]        safe_bytes;
    logic               main_new;
    logic               safe_new;
    logic               seen;
    logic [14:0]        tick_cnt;
    logic [15:0]        gap_ms;
    logic [15:0]        div_ms;
    logic signed [11:0] pos;
    logic               safe;
    logic [31:0]        rdata;
  } jmv_state_t;

  jmv_state_t cur;
  jmv_state_t next_cur;

  logic signed [11:0] main_scaled;
  logic signed [11:0] safe_scaled;
  logic               m_stat_bad;
  logic               m_range_bad;
  logic               m_mismatch;
  logic               s_stat_bad;
  logic               s_range_bad;
  logic               s_mismatch;
  logic               accept;
  logic               ms_tick;
  logic [11:0]        diff_abs;
  logic [5:0]         events;

  // A tick period the 15-bit counter cannot reach would silently shorten or stretch every timer.
  if (MS_CYCLES < 2 || MS_CYCLES > 32768) begin : g_ms_check
    $error("MS_CYCLES must lie between 2 and 32768");
  end

  // Absolute difference of two scaled positions.
  function automatic logic [11:0] jmv_abs_diff(input logic signed [11:0] a,
                                               input logic signed [11:0] b);
    logic signed [12:0] d;
    d = 13'(a) - 13'(b);
    if (d < 0) begin
      d = -d;
    end
    return d[11:0];
  endfunction

  // Main channel reads the normal bytes as received.
  jmv_decode u_main (
    .byte1      (cur.main_bytes[7:0]),
    .byte2      (cur.main_bytes[15:8]),
    .scaled     (main_scaled),
    .status_bad (m_stat_bad),
    .range_bad  (m_range_bad),
    .mismatch   (m_mismatch)
  );

  jmv_decode u_safety (
    .byte1      (~cur.safe_bytes[7:0]),
    .byte2      (~cur.safe_bytes[15:8]),
    .scaled     (safe_scaled),
    .status_bad (s_stat_bad),
    .range_bad  (s_range_bad),
    .mismatch   (s_mismatch)
  );

  // Frame filter: group and source must match and the joystick must be the CAN type.
  // Diagnostic frames carry another group number, so they never pass this filter.
  always_comb begin
    accept  = rx_valid && (rx_group == cur.group) && (rx_src_addr == cur.src_addr)
              && (cur.src_addr <= jmv_pkg::SRC_ADDR_MAX) && aux_present && type_can_stick;
    ms_tick = (cur.tick_cnt == 15'(MS_CYCLES - 1));
    diff_abs = jmv_abs_diff(main_scaled, safe_scaled);
  end

  assign aux_present    = (cur.present == jmv_pkg::PRESENT_YES);
  assign type_can_stick = (cur.dev_type == jmv_pkg::TYPE_CAN_STICK);
  assign type_open_loop = (cur.dev_type == jmv_pkg::TYPE_OPEN_LOOP)
                          || (cur.dev_type == jmv_pkg::TYPE_ANALOGUE) || type_can_stick;

  // Next-state logic: capture, validation, timing, registers.
  always_comb begin
    next_cur       = cur;
    next_cur.main_new = 1'b0;
    next_cur.safe_new = 1'b0;
    events         = 6'h00;
    if (accept && !rx_inverted) begin
      next_cur.main_bytes = rx_data[15:0];
      next_cur.main_new   = 1'b1;
    end
    if (accept && rx_inverted) begin
      next_cur.safe_bytes = rx_data[15:0];
      next_cur.safe_new   = 1'b1;
    end
    // Checks run in the cycle after a fresh capture, when decoders see the new bytes.
    if (cur.main_new || cur.safe_new) begin
      events[jmv_pkg::IRQ_MSG]        = 1'b1;
      events[jmv_pkg::IRQ_STATUS_BAD] = (cur.main_new && m_stat_bad) || (cur.safe_new && s_stat_bad);
      events[jmv_pkg::IRQ_MISMATCH]   = (cur.main_new && m_mismatch) || (cur.safe_new && s_mismatch);
      events[jmv_pkg::IRQ_RANGE]      = (cur.main_new && m_range_bad) || (cur.safe_new && s_range_bad);
    end
    // Millisecond timebase shared by both timers.
    next_cur.tick_cnt = ms_tick ? 15'h0000 : cur.tick_cnt + 15'h0001;
    if (cur.main_new) begin
      next_cur.seen   = 1'b1;
      next_cur.gap_ms = 16'h0000;
    end else if (ms_tick && cur.seen && cur.gap_ms != 16'hFFFF) begin
      next_cur.gap_ms = cur.gap_ms + 16'h0001;
    end
    events[jmv_pkg::IRQ_TIMEOUT] = cur.seen && (cur.gap_ms > cur.timeout_ms);
    if (!cur.seen || diff_abs <= {1'b0, cur.tolerance}) begin
      next_cur.div_ms = 16'h0000;
    end else if (ms_tick && cur.div_ms != 16'hFFFF) begin
      next_cur.div_ms = cur.div_ms + 16'h0001;
    end
    events[jmv_pkg::IRQ_XCHK] = cur.div_ms > cur.xchk_ms;
    if (|events[4:0]) begin
      next_cur.safe = 1'b1;
    end
    next_cur.pos = next_cur.safe ? 12'sh000 : main_scaled;
    // Register writes; the clear register is write-only.
    if (reg_wr) begin
      if (reg_addr == jmv_pkg::OFF_PRESENT) begin
        next_cur.present = reg_wdata[7:0];
      end else if (reg_addr == jmv_pkg::OFF_TYPE) begin
        next_cur.dev_type = reg_wdata[7:0];
      end else if (reg_addr == jmv_pkg::OFF_GROUP) begin
        next_cur.group = reg_wdata[15:0];
      end else if (reg_addr == jmv_pkg::OFF_SRC_ADDR) begin
        next_cur.src_addr = reg_wdata[7:0];
      end else if (reg_addr == jmv_pkg::OFF_FLOW_THR) begin
        next_cur.flow_thr = reg_wdata[7:0];
      end else if (reg_addr == jmv_pkg::OFF_TOLERANCE) begin
        next_cur.tolerance = reg_wdata[10:0];
      end else if (reg_addr == jmv_pkg::OFF_XCHK_TIME) begin
        next_cur.xchk_ms = reg_wdata[15:0];
      end else if (reg_addr == jmv_pkg::OFF_TIMEOUT) begin
        next_cur.timeout_ms = reg_wdata[15:0];
      end else if (reg_addr == jmv_pkg::OFF_IRQ_CLEAR) begin
        next_cur.irq_status = cur.irq_status & ~reg_wdata[5:0];
      end else if (reg_addr == jmv_pkg::OFF_IRQ_ENABLE) begin
        next_cur.irq_enable = reg_wdata[5:0];
      end
    end
    // A new event wins over a clear in the same cycle.
    next_cur.irq_status = next_cur.irq_status | events;
    // Read data, valid in the cycle after the strobe only.
    next_cur.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == jmv_pkg::OFF_PRESENT) begin
        next_cur.rdata = {24'h00_0000, cur.present};
      end else if (reg_addr == jmv_pkg::OFF_TYPE) begin
        next_cur.rdata = {24'h00_0000, cur.dev_type};
      end else if (reg_addr == jmv_pkg::OFF_GROUP) begin
        next_cur.rdata = {16'h0000, cur.group};
      end else if (reg_addr == jmv_pkg::OFF_SRC_ADDR) begin
        next_cur.rdata = {24'h00_0000, cur.src_addr};
      end else if (reg_addr == jmv_pkg::OFF_FLOW_THR) begin
        next_cur.rdata = {24'h00_0000, cur.flow_thr};
      end else if (reg_addr == jmv_pkg::OFF_TOLERANCE) begin
        next_cur.rdata = {21'h00_0000, cur.tolerance};
      end else if (reg_addr == jmv_pkg::OFF_XCHK_TIME) begin
        next_cur.rdata = {16'h0000, cur.xchk_ms};
      end else if (reg_addr == jmv_pkg::OFF_TIMEOUT) begin
        next_cur.rdata = {16'h0000, cur.timeout_ms};
      end else if (reg_addr == jmv_pkg::OFF_IRQ_STATUS) begin
        next_cur.rdata = {26'h000_0000, cur.irq_status};
      end else if (reg_addr == jmv_pkg::OFF_IRQ_ENABLE) begin
        next_cur.rdata = {26'h000_0000, cur.irq_enable};
      end else if (reg_addr == jmv_pkg::OFF_POSITION) begin
        next_cur.rdata = {{20{cur.pos[11]}}, cur.pos};
      end else if (reg_addr == jmv_pkg::OFF_STATE) begin
        next_cur.rdata = {31'h0000_0000, cur.safe};
      end
    end
  end

  // State register; reset takes constants only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur            <= '0;
      cur.present    <= jmv_pkg::RST_PRESENT;
      cur.dev_type   <= jmv_pkg::RST_TYPE;
      cur.group      <= jmv_pkg::RST_GROUP;
      cur.src_addr   <= jmv_pkg::RST_SRC_ADDR;
      cur.flow_thr   <= jmv_pkg::RST_FLOW_THR;
      cur.tolerance  <= jmv_pkg::RST_TOLERANCE;
      cur.xchk_ms    <= jmv_pkg::RST_XCHK_MS;
      cur.timeout_ms <= jmv_pkg::RST_TIMEOUT_MS;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata  = cur.rdata;
  assign position   = cur.pos;
  assign safe_state = cur.safe;
  assign irq        = |(cur.irq_status & cur.irq_enable);

  property p_safe_sticky;
    @(posedge clk) disable iff (!rst_n) safe_state |=> safe_state;
  endproperty
  a_safe_sticky: assert property (p_safe_sticky) else $error("safe state dropped");

  property p_safe_zero;
    @(posedge clk) disable iff (!rst_n) $past(safe_state) |-> position == 12'sh000;
  endproperty
  a_safe_zero: assert property (p_safe_zero) else $error("position not zero in safe");

  property p_range;
    @(posedge clk) disable iff (!rst_n) (cur.main_new && m_range_bad) |=> safe_state;
  endproperty
  a_range: assert property (p_range) else $error("range fault missed");

  property p_status;
    @(posedge clk) disable iff (!rst_n) (cur.safe_new && s_stat_bad) |=> safe_state;
  endproperty
  a_status: assert property (p_status) else $error("status fault missed");

  property p_mismatch;
    @(posedge clk) disable iff (!rst_n) (cur.main_new && m_mismatch) |=> safe_state;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch missed");

  property p_timeout;
    @(posedge clk) disable iff (!rst_n) (cur.seen && cur.gap_ms > cur.timeout_ms) |=> safe_state;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout missed");

  property p_xchk;
    @(posedge clk) disable iff (!rst_n) (cur.div_ms > cur.xchk_ms) |=> safe_state;
  endproperty
  a_xchk: assert property (p_xchk) else $error("divergence missed");

  property p_group;
    @(posedge clk) disable iff (!rst_n) (rx_valid && rx_group != cur.group) |=> !cur.main_new;
  endproperty
  a_group: assert property (p_group) else $error("foreign group taken");

  property p_src_filter;
    @(posedge clk) disable iff (!rst_n)
      (rx_valid && rx_src_addr != cur.src_addr) |=> !(cur.main_new || cur.safe_new);
  endproperty
  a_src_filter: assert property (p_src_filter) else $error("foreign source taken");

  property p_src_limit;
    @(posedge clk) disable iff (!rst_n)
      (rx_valid && cur.src_addr > jmv_pkg::SRC_ADDR_MAX) |=> !(cur.main_new || cur.safe_new);
  endproperty
  a_src_limit: assert property (p_src_limit) else $error("source above limit taken");

  property p_neutral;
    @(posedge clk) disable iff (!rst_n)
      (cur.main_new && cur.main_bytes[6:1] == jmv_pkg::STAT_NEUTRAL) |=> position == 12'sh000;
  endproperty
  a_neutral: assert property (p_neutral) else $error("neutral position not zero");

  property p_right;
    @(posedge clk) disable iff (!rst_n)
      (cur.main_new && cur.main_bytes[6:1] == jmv_pkg::STAT_RIGHT && !next_cur.safe)
      |=> position > 12'sh000 && position <= 12'sh3E8;
  endproperty
  a_right: assert property (p_right) else $error("right position out of range");

  property p_left;
    @(posedge clk) disable iff (!rst_n)
      (cur.main_new && cur.main_bytes[6:1] == jmv_pkg::STAT_LEFT && !next_cur.safe)
      |=> position < 12'sh000 && position >= -12'sh3E8;
  endproperty
  a_left: assert property (p_left) else $error("left position out of range");

  property p_safe_range;
    @(posedge clk) disable iff (!rst_n) (cur.safe_new && s_range_bad) |=> safe_state;
  endproperty
  a_safe_range: assert property (p_safe_range) else $error("safety range fault missed");
endmodule // jmv_validator

// ==== jmv_joystick.sv ====
// Joystick model: sends each request's main bytes as a normal frame, then its safety bytes inverted.
// Assumes the bench raises req for one cycle and leaves at least two cycles between requests.
`timescale 1ns/1ps
module jmv_joystick (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request from the bench, bytes 1 and 2 in true polarity.
  input  wire logic        req,
  input  wire logic [15:0] req_group,
  input  wire logic [7:0]  req_src,
  input  wire logic [15:0] req_main,
  input  wire logic [15:0] req_safe,
  // Frame towards the validator.
  output logic             rx_valid,
  output logic             rx_inverted,
  output logic [15:0]      rx_group,
  output logic [7:0]       rx_src_addr,
  output logic [63:0]      rx_data
);
  logic [1:0]  step;
  logic [15:0] main_q;
  logic [15:0] safe_q;

  // Data lines toggle outside frames, so stale bytes never pass for a frame.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step        <= 2'h0;
      main_q      <= '0;
      safe_q      <= '0;
      rx_valid    <= 1'b0;
      rx_inverted <= 1'b0;
      rx_group    <= '0;
      rx_src_addr <= '0;
      rx_data     <= '0;
    end else begin
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
      if (req) begin
        step        <= 2'h1;
        main_q      <= req_main;
        safe_q      <= req_safe;
        rx_group    <= req_group;
        rx_src_addr <= req_src;
      end else if (step == 2'h1) begin
        step        <= 2'h2;
        rx_valid    <= 1'b1;
        rx_inverted <= 1'b0;
        rx_data     <= {$urandom(), 16'($urandom()), main_q};
      end else if (step == 2'h2) begin
        step        <= 2'h0;
        rx_valid    <= 1'b1;
        rx_inverted <= 1'b1;
        rx_data     <= {$urandom(), 16'($urandom()), ~safe_q};
      end
    end
  end
endmodule // jmv_joystick

// ==== tb.sv ====
// Self-checking bench for the validator, with the joystick model on the frame side.
// Assumes the model's frame spacing and the two-cycle result latency of the validator.
`timescale 1ns/1ps
module tb;
  // Register port and model request.
  logic               clk, rst_n, reg_wr, reg_rd, req;
  logic [7:0]         reg_addr, req_src, rx_src_addr;
  logic [31:0]        reg_wdata, reg_rdata, rv;
  logic [15:0]        req_group, req_main, req_safe, rx_group;
  logic               rx_valid, rx_inverted;
  logic [63:0]        rx_data;
  // Results and bookkeeping.
  logic signed [11:0] position;
  logic               safe_state, aux_present, type_can_stick, type_open_loop, irq;
  int                 n_errors, checked;
  logic [5:0]         st;
  logic [9:0]         mag;
  logic [31:0] rst_tab [8] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_FDD6, 32'h0000_004E,
    32'h0000_000A, 32'(jmv_pkg::RST_TOLERANCE), 32'(jmv_pkg::RST_XCHK_MS),
    32'(jmv_pkg::RST_TIMEOUT_MS)};
  logic [7:0]  ty_tab [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h14};
  logic [5:0]  f_st [7] = '{6'h14, 6'h20, 6'h00, 6'h10, 6'h10, 6'h10, 6'h01};
  logic [9:0]  f_m [7] = '{10'h1F4, 10'h1F4, 10'h1F4, 10'h3E9, 10'h1F4, 10'h000, 10'h005};
  logic [9:0]  f_s [7] = '{10'h1F4, 10'h1F4, 10'h1F4, 10'h3E9, 10'h3E9, 10'h000, 10'h005};
  int          f_b [7] = '{0, 0, 0, 1, 1, 2, 2};

  jmv_validator dut_u (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_inverted(rx_inverted), .rx_group(rx_group), .rx_src_addr(rx_src_addr),
    .rx_data(rx_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .position(position), .safe_state(safe_state),
    .aux_present(aux_present), .type_can_stick(type_can_stick),
    .type_open_loop(type_open_loop), .irq(irq));
  jmv_joystick stick_u (.clk(clk), .rst_n(rst_n), .req(req), .req_group(req_group),
    .req_src(req_src), .req_main(req_main), .req_safe(req_safe), .rx_valid(rx_valid),
    .rx_inverted(rx_inverted), .rx_group(rx_group), .rx_src_addr(rx_src_addr),
    .rx_data(rx_data));

  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // magnitude spread over bytes 1 and 2
  function automatic logic [15:0] enc(logic [5:0] s, logic [9:0] m);
    return {m[7:0], m[9], s, m[8]};
  endfunction
  function automatic logic signed [11:0] exp_pos(logic [5:0] s, logic [9:0] m);
    if (s == jmv_pkg::STAT_LEFT) return -$signed({2'b00, m});
    if (s == jmv_pkg::STAT_RIGHT) return $signed({2'b00, m});
    return 12'sh000;
  endfunction

  // Comparisons count every call and report each mismatch at once.
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_pos(input logic signed [11:0] e);
    checked++;
    if (position !== e) begin
      n_errors++;
      $display("CHECK FAILED position expected %0d seen %0d", e, position);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Bus tasks start just after a rising edge; a write leaves one idle cycle behind it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
    @(posedge clk);
  endtask
  // One frame pair; the wait covers both copies and the result latency.
  task automatic send(input logic [15:0] g, input logic [7:0] s,
                      input logic [15:0] m, input logic [15:0] sf);
    req       <= 1'b1;
    req_group <= g;
    req_src   <= s;
    req_main  <= m;
    req_safe  <= sf;
    @(posedge clk);
    req <= 1'b0;
    repeat (7) @(posedge clk);
  endtask
  task automatic frame(input logic [5:0] s, input logic [9:0] m);
    send(16'hFDD6, 8'h4E, enc(s, m), enc(s, m));
  endtask
  task automatic setup();
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wr(jmv_pkg::OFF_PRESENT, 32'h0000_00FF);
    wr(jmv_pkg::OFF_TYPE, 32'h0000_0014);
  endtask
  // Waits a bounded time for safe state, then checks its cause and that it holds.
  task automatic wait_safe(input int bound, input int b);
    int i;
    for (i = 0; i < bound && safe_state !== 1'b1; i++) @(posedge clk);
    chk("safe_state", 32'h1, 32'(safe_state));
    if (safe_state !== 1'b1) results();
    rd(jmv_pkg::OFF_IRQ_STATUS);
    chk("cause bit", 32'h1, 32'(rv[b]));
    rd(jmv_pkg::OFF_STATE);
    chk("state reg", 32'h1, rv);
    frame(jmv_pkg::STAT_RIGHT, 10'h1F4);
    chk_pos(12'sh000);
    chk("safe held", 32'h1, 32'(safe_state));
  endtask

  // Main sequence.
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; req = 1'b0; reg_addr = '0; reg_wdata = '0;
    req_group = '0; req_src = '0; req_main = '0; req_safe = '0;
    n_errors = 0;
    checked = 0;
    void'($urandom(75728));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      rd(8'(k * 4));
      chk("reset value", rst_tab[k], rv);
    end
    wr(jmv_pkg::OFF_IRQ_STATUS, 32'h0000_003F);
    rd(jmv_pkg::OFF_IRQ_STATUS);
    chk("status read-only", 32'h0, rv);
    rd(8'h3C);
    chk("unmapped", 32'h0, rv);
    for (int k = 0; k < 3; k++) begin
      wr(jmv_pkg::OFF_PRESENT,
         (k == 0) ? 32'h0000_007F : (k == 1) ? 32'h0000_0000 : 32'h0000_00FF);
      chk("aux_present", 32'(k == 2), 32'(aux_present));
    end
    for (int k = 0; k < 5; k++) begin
      wr(jmv_pkg::OFF_TYPE, 32'(ty_tab[k]));
      rd(jmv_pkg::OFF_TYPE);
      chk("type", 32'(ty_tab[k]), rv);
      chk("type_can_stick", 32'(k == 4), 32'(type_can_stick));
      chk("type_open_loop", 32'(k == 0 || k == 3 || k == 4), 32'(type_open_loop));
    end
    wr(jmv_pkg::OFF_IRQ_ENABLE, 32'h0000_0020);
    for (int k = 0; k < 24; k++) begin
      st = (k % 3 == 0) ? jmv_pkg::STAT_RIGHT : (k % 3 == 1) ? jmv_pkg::STAT_LEFT
         : jmv_pkg::STAT_NEUTRAL;
      mag = (k < 3) ? 10'h3E8 : (k < 6) ? 10'h001 : 10'($urandom_range(1000, 1));
      if (st == jmv_pkg::STAT_NEUTRAL) mag = 10'h000;
      frame(st, mag);
      chk_pos(exp_pos(st, mag));
      rd(jmv_pkg::OFF_POSITION);
      chk("position reg", 32'(exp_pos(st, mag)), rv);
    end
    chk("irq", 32'h1, 32'(irq));
    wr(jmv_pkg::OFF_IRQ_CLEAR, 32'h0000_0020);
    chk("irq cleared", 32'h0, 32'(irq));
    frame(jmv_pkg::STAT_RIGHT, 10'h12C);
    wr(jmv_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
    chk("irq masked", 32'h0, 32'(irq));
    rd(jmv_pkg::OFF_IRQ_STATUS);
    chk("message bit", 32'h1, 32'(rv[jmv_pkg::IRQ_MSG]));
    send(jmv_pkg::GRP_EXT_1, 8'h4E, enc(6'h04, 10'h2BC), enc(6'h04, 10'h2BC));
    chk_pos(12'sh12C);
    send(16'hFECA, 8'h4E, enc(6'h04, 10'h2BC), enc(6'h04, 10'h2BC));
    chk_pos(12'sh12C);
    send(16'hFDD6, 8'h4F, enc(6'h04, 10'h2BC), enc(6'h04, 10'h2BC));
    chk_pos(12'sh12C);
    wr(jmv_pkg::OFF_SRC_ADDR, 32'h0000_00FE);
    send(16'hFDD6, 8'hFE, enc(6'h04, 10'h2BC), enc(6'h04, 10'h2BC));
    chk_pos(12'sh12C);
    wr(jmv_pkg::OFF_SRC_ADDR, 32'h0000_00FD);
    wr(jmv_pkg::OFF_GROUP, 32'(jmv_pkg::GRP_BASIC_2));
    send(jmv_pkg::GRP_BASIC_2, 8'hFD, enc(6'h10, 10'h190), enc(6'h10, 10'h190));
    chk_pos(12'sh190);
    for (int k = 0; k < 7; k++) begin
      setup();
      send(16'hFDD6, 8'h4E, enc(f_st[k], f_m[k]), enc(f_st[k], f_s[k]));
      wait_safe(20, f_b[k]);
    end
    setup();
    wr(jmv_pkg::OFF_XCHK_TIME, 32'h0000_0000);
    send(16'hFDD6, 8'h4E, enc(6'h10, 10'h1F4), enc(6'h10, 10'h1FE));
    repeat (22000) @(posedge clk);
    chk("no divergence", 32'h0, 32'(safe_state));
    send(16'hFDD6, 8'h4E, enc(6'h10, 10'h1F4), enc(6'h10, 10'h1FF));
    wait_safe(25000, jmv_pkg::IRQ_XCHK);
    setup();
    wr(jmv_pkg::OFF_TIMEOUT, 32'h0000_0000);
    frame(jmv_pkg::STAT_RIGHT, 10'h064);
    chk("not yet", 32'h0, 32'(safe_state));
    wait_safe(25000, jmv_pkg::IRQ_TIMEOUT);
    results();
  end
endmodule // tb
